// ### src/lfdc_pkg.sv
package lfdc_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int NUM_OUT        = 24;
  localparam int NUM_CH         = 8;
  localparam int NUM_COLOR      = 3;
  localparam int STATUS_W       = 25;
  localparam int IDX_W          = 5;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int VALID_TIME_NS  = 1000;
  localparam int VALID_CYCLES   =
    (VALID_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYCLES    = 4;
  localparam int CNT_W          = 9;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ONOFF   = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_HOLDER  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_STATE   = 8'h10;
  localparam logic [7:0] ADDR_SINKS   = 8'h14;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int SEL_LSB           = 21;
  localparam int SEL_MSB           = 23;
  localparam int STATE_TSD_BIT     = 0;
  localparam int STATE_FLAG_BIT    = 1;
  localparam int STATE_BUSY_BIT    = 2;
  localparam int STATE_VALID_BIT   = 3;
  localparam logic [23:0] ONOFF_RST = 24'h000000;
  localparam logic [2:0]  SEL_RST   = 3'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {LFDC_SEQ_IDLE, LFDC_SEQ_RUN} lfdc_seq_t;

endpackage

// ### src/lfdc_top.sv
`timescale 1ns/10ps
// Operation
// - Open mode, enabled, below threshold sets open bit
// - Short mode, enabled, above threshold sets short bit
// - Outputs programmed off report zero faults
// - Select codes 0-3 open, 4-7 short
// - Only the selected fault type is reported
// - Results invalid until 1 us after blank falls
// - Blank rising edge freezes results into holder
// - Holder transparent while blank low, 1 us settle
// - Latch strobe copies holder into shift register
// - Results invalid while thermal shutdown active
// - Overtemp sets flag and forces outputs off
// - Outputs off until cooled below hysteresis point
// - Overtemp flag held until a latch strobe, even one that loads no status
// - Latch strobe clears flag only when cooled
// - Staggered switching R,G,B per channel 0..7
// - Turn-off uses the same stagger as turn-on
// - Load status only when shift top bit zero
// - No new shift data means strobe loads no status
// - Status shifted out one bit per serial clock
// - Select field sits at control bits 23..21
module lfdc_top
  import lfdc_pkg::*;
(
  input  logic                  aclk,
  input  logic                  aresetn,
  input  logic [31:0]           s_axi_awaddr,
  input  logic                  s_axi_awvalid,
  output logic                  s_axi_awready,
  input  logic [31:0]           s_axi_wdata,
  input  logic [3:0]            s_axi_wstrb,
  input  logic                  s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  logic                  s_axi_bready,
  input  logic [31:0]           s_axi_araddr,
  input  logic                  s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  logic                  s_axi_rready,
  input  logic                  blank,
  input  logic                  latch_strobe,
  input  logic                  serial_clk,
  input  logic                  shift_top_bit,
  input  logic                  shift_new_data,
  input  logic [NUM_OUT-1:0]    pin_below_thr,
  input  logic [NUM_OUT-1:0]    pin_above_thr,
  input  logic                  temp_above_thr,
  input  logic                  temp_below_hys,
  output logic [NUM_OUT-1:0]    sink_on,
  output logic [STATUS_W-1:0]   status_word,
  output logic                  status_load,
  output logic                  serial_data_out,
  output logic                  thermal_shutdown
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int SYN_W = 2 * NUM_OUT + 5;
  // Blank idles high; its stages reset high so no false edge follows reset
  localparam logic [SYN_W-1:0] SYN_RST = SYN_W'(1);
  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  logic [SYN_W-1:0] pin_bus;

  assign pin_bus = {pin_above_thr, pin_below_thr, temp_below_hys,
                    temp_above_thr, serial_clk, latch_strobe, blank};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syn1_q <= SYN_RST;
      syn2_q <= SYN_RST;
    end else begin
      syn1_q <= pin_bus;
      syn2_q <= syn1_q;
    end
  end

  logic               blank_s;
  logic               lat_s;
  logic               sclk_s;
  logic               hot_s;
  logic               cool_s;
  logic [NUM_OUT-1:0] below_s;
  logic [NUM_OUT-1:0] above_s;

  assign blank_s = syn2_q[0];
  assign lat_s   = syn2_q[1];
  assign sclk_s  = syn2_q[2];
  assign hot_s   = syn2_q[3];
  assign cool_s  = syn2_q[4];
  assign below_s = syn2_q[5 +: NUM_OUT];
  assign above_s = syn2_q[5 + NUM_OUT +: NUM_OUT];

  logic blank_d1_q;
  logic lat_d1_q;
  logic sclk_d1_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_d1_q <= 1'b1;
      lat_d1_q   <= 1'b0;
      sclk_d1_q  <= 1'b0;
    end else begin
      blank_d1_q <= blank_s;
      lat_d1_q   <= lat_s;
      sclk_d1_q  <= sclk_s;
    end
  end

  logic blank_fall;
  logic blank_rise;
  logic lat_rise;
  logic sclk_rise;

  assign blank_fall = blank_d1_q & ~blank_s;
  assign blank_rise = ~blank_d1_q & blank_s;
  assign lat_rise   = ~lat_d1_q & lat_s;
  assign sclk_rise  = ~sclk_d1_q & sclk_s;

  // ----------------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------------
  logic [NUM_OUT-1:0] onoff_q;
  logic [2:0]         sel_q;
  logic               short_mode;

  assign short_mode = sel_q[2];

  // ----------------------------------------------------------------------
  // Fault detection and holder
  // ----------------------------------------------------------------------
  logic [NUM_OUT-1:0] detect_raw;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_det
    assign detect_raw[i] = onoff_q[i] &
                           (short_mode ? above_s[i]
                                       : below_s[i]);
  end

  logic [NUM_OUT-1:0] detect_prev_q;
  logic [CNT_W-1:0]   settle_q;
  logic [NUM_OUT-1:0] holder_q;
  logic               overtemp_flag_q;
  logic               thermal_shutdown_q;
  logic               settled;

  assign settled = (settle_q == CNT_W'(VALID_CYCLES));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_prev_q <= '0;
    end else begin
      detect_prev_q <= detect_raw;
    end
  end

  // Settle timer restarts on blank fall, any detector change, or shutdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_q <= '0;
    end else if (blank_fall || detect_raw != detect_prev_q ||
                 thermal_shutdown_q) begin
      settle_q <= '0;
    end else if (!blank_s && !settled) begin
      settle_q <= settle_q + CNT_W'(1);
    end
  end

  // Transparent while blank low and settled; frozen once blank is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holder_q <= '0;
    end else if (!blank_s && settled && !thermal_shutdown_q) begin
      holder_q <= detect_raw;
    end
  end

  // ----------------------------------------------------------------------
  // Over-temperature
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_shutdown_q <= 1'b0;
    end else if (hot_s) begin
      thermal_shutdown_q <= 1'b1;
    end else if (cool_s) begin
      thermal_shutdown_q <= 1'b0;
    end
  end

  // Set wins over the strobe clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overtemp_flag_q <= 1'b0;
    end else if (hot_s) begin
      overtemp_flag_q <= 1'b1;
    end else if (lat_rise && cool_s) begin
      overtemp_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status transfer and serial out
  // ----------------------------------------------------------------------
  logic                load_ok;
  logic [STATUS_W-1:0] status_q;
  logic                status_load_q;
  logic [STATUS_W-1:0] shreg_q;

  assign load_ok = lat_rise & shift_new_data
                   & ~shift_top_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q      <= '0;
      status_load_q <= 1'b0;
    end else begin
      status_load_q <= load_ok;
      if (load_ok) begin
        status_q <= {overtemp_flag_q, holder_q};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= '0;
    end else if (load_ok) begin
      shreg_q <= {overtemp_flag_q, holder_q};
    end else if (sclk_rise) begin
      shreg_q <= {shreg_q[STATUS_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Staggered output switching
  // ----------------------------------------------------------------------
  lfdc_seq_t          seq_q;
  logic [IDX_W-1:0]   idx_q;
  logic [CNT_W-1:0]   step_q;
  logic [NUM_OUT-1:0] sink_q;
  logic [NUM_OUT-1:0] target;
  logic               seq_trig;
  logic               step_done;

  assign target    = blank_s ? '0 : onoff_q;
  assign seq_trig  = blank_fall | blank_rise | lat_rise;
  assign step_done = (step_q == CNT_W'(STEP_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q  <= LFDC_SEQ_IDLE;
      idx_q  <= '0;
      step_q <= '0;
    end else if (seq_trig) begin
      seq_q  <= LFDC_SEQ_RUN;
      idx_q  <= '0;
      step_q <= '0;
    end else begin
      unique case (seq_q)
        LFDC_SEQ_IDLE: begin
          step_q <= '0;
        end
        LFDC_SEQ_RUN: begin
          if (step_done) begin
            step_q <= '0;
            if (idx_q == IDX_W'(NUM_OUT - 1)) begin
              seq_q <= LFDC_SEQ_IDLE;
              idx_q <= '0;
            end else begin
              idx_q <= idx_q + IDX_W'(1);
            end
          end else begin
            step_q <= step_q + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Index order is R0,G0,B0,R1,...,B7; shutdown forces all off at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sink_q <= '0;
    end else if (thermal_shutdown_q) begin
      sink_q <= '0;
    end else if (seq_q == LFDC_SEQ_RUN && step_done) begin
      sink_q[idx_q] <= target[idx_q];
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_go;
  logic        wr_hit;

  assign wr_go  = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_hit = (waddr_q == ADDR_ONOFF) | (waddr_q == ADDR_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= ~aw_have_q & ~(s_axi_awvalid & awready_q) & ~bvalid_q;
      wready_q  <= ~w_have_q & ~(s_axi_wvalid & wready_q) & ~bvalid_q;
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        waddr_q   <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      onoff_q <= ONOFF_RST;
      sel_q   <= SEL_RST;
    end else if (wr_go) begin
      if (waddr_q == ADDR_ONOFF) begin
        for (int b = 0; b < 3; b++) begin
          if (wstrb_q[b]) begin
            onoff_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
          end
        end
      end
      if (waddr_q == ADDR_CTRL && wstrb_q[2]) begin
        sel_q <= wdata_q[SEL_MSB:SEL_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [7:0]  raddr;

  assign raddr = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (raddr)
      ADDR_ONOFF:  rd_mux[NUM_OUT-1:0] = onoff_q;
      ADDR_CTRL:   rd_mux[SEL_MSB:SEL_LSB] = sel_q;
      ADDR_HOLDER: rd_mux[NUM_OUT-1:0] = holder_q;
      ADDR_STATUS: rd_mux[STATUS_W-1:0] = status_q;
      ADDR_STATE: begin
        rd_mux[STATE_TSD_BIT]   = thermal_shutdown_q;
        rd_mux[STATE_FLAG_BIT]  = overtemp_flag_q;
        rd_mux[STATE_BUSY_BIT]  = (seq_q == LFDC_SEQ_RUN);
        rd_mux[STATE_VALID_BIT] = settled;
      end
      ADDR_SINKS:  rd_mux[NUM_OUT-1:0] = sink_q;
      default:     rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_q & ~(s_axi_arvalid & arready_q);
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready    = awready_q;
  assign s_axi_wready     = wready_q;
  assign s_axi_bvalid     = bvalid_q;
  assign s_axi_bresp      = bresp_q;
  assign s_axi_arready    = arready_q;
  assign s_axi_rvalid     = rvalid_q;
  assign s_axi_rdata      = rdata_q;
  assign s_axi_rresp      = rresp_q;
  assign sink_on          = sink_q;
  assign status_word      = status_q;
  assign status_load      = status_load_q;
  assign serial_data_out  = shreg_q[STATUS_W-1];
  assign thermal_shutdown = thermal_shutdown_q;

endmodule

// ### sim/lfdc_top_properties.sv
`timescale 1ns/10ps
module lfdc_top_properties
  import lfdc_pkg::*;
(
  input logic                aclk,
  input logic                aresetn,
  input logic [1:0]          s_axi_bresp,
  input logic                s_axi_bvalid,
  input logic                s_axi_bready,
  input logic [31:0]         s_axi_rdata,
  input logic                s_axi_rvalid,
  input logic                s_axi_rready,
  input logic                shift_top_bit,
  input logic                shift_new_data,
  input logic                temp_above_thr,
  input logic                temp_below_hys,
  input logic [NUM_OUT-1:0]  sink_on,
  input logic [STATUS_W-1:0] status_word,
  input logic                status_load,
  input logic                serial_data_out,
  input logic                thermal_shutdown
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_load_pulse: assert property (status_load |=> !status_load)
    else $error("status load longer than one cycle");
  a_word_hold: assert property (!status_load |-> $stable(status_word))
    else $error("status word changed without a load");
  a_load_gate: assert property (status_load |->
      $past(shift_new_data) && !$past(shift_top_bit))
    else $error("status loaded while refused");
  a_serial_data_out_msb: assert property (status_load |->
      serial_data_out == status_word[STATUS_W-1])
    else $error("serial output not at top status bit");
  a_shut_sinks: assert property (
      thermal_shutdown && $past(thermal_shutdown) |-> sink_on == '0)
    else $error("sink on during shutdown");
  a_one_step: assert property (
      !thermal_shutdown && !$past(thermal_shutdown) |->
      $countones(sink_on ^ $past(sink_on)) <= 1)
    else $error("several sinks switched together");
  a_shut_cause: assert property ($rose(thermal_shutdown) |->
      $past(temp_above_thr) || $past(temp_above_thr, 2) ||
      $past(temp_above_thr, 3) || $past(temp_above_thr, 4))
    else $error("shutdown without overtemperature");
  a_shut_hold: assert property ($fell(thermal_shutdown) |->
      $past(temp_below_hys) || $past(temp_below_hys, 2) ||
      $past(temp_below_hys, 3) || $past(temp_below_hys, 4))
    else $error("shutdown ended before cooling");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind lfdc_top lfdc_top_properties i_lfdc_top_properties (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .shift_top_bit,
  .shift_new_data, .temp_above_thr, .temp_below_hys, .sink_on,
  .status_word, .status_load, .serial_data_out, .thermal_shutdown
);

// ### sim/lfdc_ctrl_model.sv
`timescale 1ns/10ps
module lfdc_ctrl_model
  import lfdc_pkg::*;
#(
  parameter int MIN_LOW = VALID_CYCLES
)(
  input  logic aclk,
  input  logic aresetn,
  input  logic blank_cmd,
  input  logic strobe_cmd,
  output logic blank,
  output logic latch_strobe
);
  logic [CNT_W:0] low_cnt_q;

  // Blank is only released once its own low time has been counted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank <= 1'b1;
    end else if (!blank_cmd) begin
      blank <= 1'b0;
    end else if (low_cnt_q >= MIN_LOW) begin
      blank <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || blank) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q < MIN_LOW) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    latch_strobe <= aresetn & strobe_cmd;
  end
endmodule

// ### sim/lfdc_top_tb_top.sv
`timescale 1ns/10ps
module lfdc_top_tb_top
  import lfdc_pkg::*;
;
  localparam int LOW = VALID_CYCLES + 128;
  typedef struct packed {
    logic [2:0]  sel;
    logic [23:0] on, lo, hi, want;
  } lfdc_row_t;
  logic                aclk, aresetn, blank, latch_strobe, serial_clk;
  logic                shift_top_bit, shift_new_data, temp_above_thr;
  logic                temp_below_hys, status_load, serial_data_out;
  logic                thermal_shutdown, blank_cmd, strobe_cmd, ld;
  logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                s_axi_arvalid, s_axi_arready;
  logic                s_axi_rvalid, s_axi_rready;
  logic [1:0]          s_axi_bresp, s_axi_rresp, r;
  logic [3:0]          s_axi_wstrb;
  logic [31:0]         s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [31:0]         s_axi_rdata, d;
  logic [NUM_OUT-1:0]  pin_below_thr, pin_above_thr, sink_on;
  logic [STATUS_W-1:0] status_word;
  int                  err_total, checks, cycles;
  lfdc_row_t           rows [8] = '{
    '{3'h0, 24'hFFFFFF, 24'h000005, 24'hFFFFFF, 24'h000005},
    '{3'h1, 24'h00000F, 24'h0000FF, 24'h000000, 24'h00000F},
    '{3'h2, 24'hFFFFFF, 24'h800000, 24'h000000, 24'h800000},
    '{3'h3, 24'hF0F0F0, 24'hFFFFFF, 24'hFFFFFF, 24'hF0F0F0},
    '{3'h4, 24'hFFFFFF, 24'hFFFFFF, 24'hA00001, 24'hA00001},
    '{3'h5, 24'h0000F0, 24'h000000, 24'hFFFFFF, 24'h0000F0},
    '{3'h6, 24'hFFFFFF, 24'h000000, 24'h000000, 24'h000000},
    '{3'h7, 24'h123456, 24'hFFFFFF, 24'hFFFFFF, 24'h123456}};

  lfdc_top i_lfdc_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .blank, .latch_strobe, .serial_clk,
    .shift_top_bit, .shift_new_data, .pin_below_thr, .pin_above_thr,
    .temp_above_thr, .temp_below_hys, .sink_on, .status_word,
    .status_load, .serial_data_out, .thermal_shutdown);
  lfdc_ctrl_model #(.MIN_LOW(LOW)) i_lfdc_ctrl_model (
    .aclk, .aresetn, .blank_cmd, .strobe_cmd, .blank, .latch_strobe);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Latch pulse of four cycles; ld tells whether a status load followed
  task automatic strobe(input logic nd, input logic top);
    ld = 1'b0;
    shift_new_data <= nd;
    shift_top_bit <= top;
    strobe_cmd <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge aclk);
      if (status_load === 1'b1) ld = 1'b1;
      if (i == 3) {strobe_cmd, shift_new_data} <= 2'h0;
    end
  endtask

  task automatic bphase;
    blank_cmd <= 1'b0;
    cyc(LOW + 20);
    blank_cmd <= 1'b1;
    cyc(8);
  endtask

  // Each sink change must be one bit, in index order, at a fixed pace
  task automatic watch;
    logic [23:0] p;
    int k, g;
    p = sink_on;
    k = 0;
    g = 0;
    repeat (200) begin
      @(posedge aclk);
      g++;
      if (sink_on !== p) begin
        chk(sink_on ^ p, 32'h1 << k);
        if (k > 0) chk(g, STEP_CYCLES);
        k++;
        g = 0;
        p = sink_on;
      end
    end
    chk(k, NUM_OUT);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
    {s_axi_arvalid, s_axi_rready, serial_clk, strobe_cmd} <= 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} <= '0;
    s_axi_wstrb <= 4'hF;
    {shift_top_bit, shift_new_data, temp_above_thr} <= 3'h0;
    temp_below_hys <= 1'b1;
    blank_cmd <= 1'b1;
    {pin_below_thr, pin_above_thr} <= '0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(1);
    chk(sink_on, 32'h0);
    chk(status_word, 32'h0);
    rd(ADDR_ONOFF);
    chk(d, {8'h00, ONOFF_RST});
    rd(ADDR_CTRL);
    chk(d, {8'h00, SEL_RST, 21'h0});
    rd(8'h18);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(ADDR_HOLDER, 32'h1);
    chk(r, RESP_SLVERR);
    foreach (rows[i]) begin
      wr(ADDR_ONOFF, {8'h00, rows[i].on});
      wr(ADDR_CTRL, {8'h00, rows[i].sel, 21'h0});
      chk(r, RESP_OKAY);
      pin_below_thr <= rows[i].lo;
      pin_above_thr <= rows[i].hi;
      bphase();
      strobe(1'b1, 1'b0);
      chk(ld, 1'b1);
      chk(status_word, {1'b0, rows[i].want});
      rd(ADDR_HOLDER);
      chk(d, {8'h00, rows[i].want});
    end
    for (int i = STATUS_W - 1; i >= 0; i--) begin
      chk(serial_data_out, (i < NUM_OUT) ? rows[7].want[i] : 1'b0);
      serial_clk <= 1'b1;
      cyc(4);
      serial_clk <= 1'b0;
      cyc(4);
    end
    strobe(1'b1, 1'b1);
    chk(ld, 1'b0);
    strobe(1'b0, 1'b0);
    chk(ld, 1'b0);
    pin_above_thr <= '0;
    cyc(LOW);
    strobe(1'b1, 1'b0);
    chk(status_word, {1'b0, rows[7].want});
    rd(ADDR_STATUS);
    chk(d, {7'h00, 1'b0, rows[7].want});
    blank_cmd <= 1'b0;
    cyc(100);
    rd(ADDR_HOLDER);
    chk(d, {8'h00, rows[7].want});
    cyc(LOW);
    rd(ADDR_HOLDER);
    chk(d, 32'h0);
    chk(sink_on, rows[7].on);
    rd(ADDR_SINKS);
    chk(d, {8'h00, rows[7].on});
    temp_above_thr <= 1'b1;
    temp_below_hys <= 1'b0;
    cyc(10);
    chk({thermal_shutdown, sink_on}, 32'h1000000);
    rd(ADDR_STATE);
    chk(d[1:0], 2'h3);
    strobe(1'b1, 1'b0);
    chk(status_word[STATUS_W-1], 1'b1);
    temp_above_thr <= 1'b0;
    cyc(10);
    chk(thermal_shutdown, 1'b1);
    strobe(1'b1, 1'b0);
    chk(status_word[STATUS_W-1], 1'b1);
    temp_below_hys <= 1'b1;
    cyc(10);
    chk(thermal_shutdown, 1'b0);
    strobe(1'b1, 1'b0);
    strobe(1'b1, 1'b0);
    chk(status_word[STATUS_W-1], 1'b0);
    cyc(120);
    chk(sink_on, rows[7].on);
    blank_cmd <= 1'b1;
    cyc(120);
    wr(ADDR_ONOFF, 32'hFFFFFF);
    blank_cmd <= 1'b0;
    watch();
    cyc(LOW);
    blank_cmd <= 1'b1;
    watch();
    aresetn <= 1'b0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(1);
    rd(ADDR_ONOFF);
    chk(d, {8'h00, ONOFF_RST});
    test_done();
  end
endmodule
